// [rtl/pebp_top.sv]
// port E pin function selection, pull and reduced drive control with AXI4-Lite registers
// assumes pins arrive asynchronously; core bus control signals are on aclk
//
// Summary of operation
// - pipe status enable in expanded modes drives PE6/PE5; else GPIO or clock test on PE6.
// - pipe, strobe, read/write, strobe-select bits: normal write once, special skip first write.
// - E-clock disable bit: once in normal single chip, always special single, else never.
// - E-clock disable clear gives E clock on PE4; single chip also needs stretch clear.
// - E-clock pin is an input in peripheral mode; otherwise an output while carrying E clock, else GPIO.
// - low strobe enable drives PE3 strobe except single chip and normal narrow.
// - normal expanded narrow forces PE3 output high during and after reset.
// - special expanded, strobe enable, tagging: low PE3 at E fall tags low byte.
// - read/write enable outside single chip drives PE2 as read/write, else GPIO.
// - calibration enable always writable; drives PE7 in single, peripheral or no-data-enable.
// - expanded with no-data-enable clear: PE7 is data enable or inverted E clock.
// - strobe select ignored in single chip and peripheral; PE7 calibration or GPIO.
// - inverted E clock follows E clock inverted, may idle high.
// - pull control always accessible, absent in peripheral mode, pulls only input pins.
// - port E pull enable acts only on input pins PE7 and PE3 to PE0.
// - port A and B pulls inactive while the port carries address/data.
// - port G and H pull enables act on all their input pins.
// - each reduced drive bit weakens all outputs of its port, any function.
// - reduced drive absent in peripheral; normal write once, special skip first write.
// - no-data-enable set moves PE7 to calibration or GPIO; ignored single/peripheral.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns

module pebp_top #(
    parameter int ADDR_W = 8
) (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // mode straps and core status
    input wire logic [2:0] mode_pins,
    input wire logic e_stretch,
    input wire logic debug_tag_active,
    input wire pebp_pkg::pebp_busctl_t busctl,
    // port E general purpose data and direction
    input wire logic [7:0] gpio_data,
    input wire logic [7:0] gpio_dir,
    // port E pads
    input wire logic [7:0] pe_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe,
    // direction of the other ports, 1 = output
    input wire logic [7:0] dir_a,
    input wire logic [7:0] dir_b,
    input wire logic [7:0] dir_g,
    input wire logic [7:0] dir_h,
    // pad controls
    output logic [7:0] pull_a,
    output logic [7:0] pull_b,
    output logic [7:0] pull_e,
    output logic [7:0] pull_g,
    output logic [7:0] pull_h,
    output logic [4:0] weak_drive,
    // debug
    output logic tag_low_byte
);

    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
        $error("pebp_top: ADDR_W must lie between 6 and 32");
    end

    localparam logic [ADDR_W-1:0] A_PASG = ADDR_W'({pebp_pkg::IDX_PASG, 2'b00});
    localparam logic [ADDR_W-1:0] A_PULL = ADDR_W'({pebp_pkg::IDX_PULL, 2'b00});
    localparam logic [ADDR_W-1:0] A_WDRV = ADDR_W'({pebp_pkg::IDX_WDRV, 2'b00});
    localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'({pebp_pkg::IDX_STATUS, 2'b00});

    // synchronisers; first stage feeds only the second
    logic [7:0] pe_s1;
    logic [7:0] pe_s2;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;

    always_ff @(posedge aclk) begin
        pe_s1 <= pe_in;
        pe_s2 <= pe_s1;
        mode_s1 <= mode_pins;
        mode_s2 <= mode_s1;
    end

    // mode is caught while reset is held and frozen after release
    pebp_pkg::pebp_mode_t op_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_mode <= pebp_pkg::pebp_mode_t'(mode_s2);
        end
    end

    wire is_special = op_mode[2];
    wire is_single = (op_mode == pebp_pkg::MODE_NORM_SINGLE) || (op_mode == pebp_pkg::MODE_SPEC_SINGLE) ||
                     (op_mode == 3'h7);
    wire is_periph = (op_mode == pebp_pkg::MODE_PERIPHERAL);
    wire is_exp = !is_single && !is_periph;
    wire is_spec_exp = is_exp && is_special;
    wire is_norm_narrow = (op_mode == pebp_pkg::MODE_NORM_EXP_NARROW);

    wire [2:0] rst_mode = mode_s2;
    wire [7:0] pasg_rst_val =
        (rst_mode == pebp_pkg::MODE_PERIPHERAL) ? pebp_pkg::PASG_RST_PERIPH :
        (rst_mode == pebp_pkg::MODE_NORM_SINGLE) ? pebp_pkg::PASG_RST_NORM_SINGLE :
        rst_mode[2] ? pebp_pkg::PASG_RST_SPECIAL : pebp_pkg::PASG_RST_NORM_EXP;

    // registers
    pebp_pkg::pebp_pasg_t pasg;
    logic [7:0] pasg_seen;
    logic [7:0] pull_ctl;
    logic [7:0] wdrv;
    logic wdrv_seen;
    logic narrow_hold;

    // AXI write channel holding
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;

    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire do_write = aw_full && w_full && !bvalid;
    wire next_bvalid = do_write || (bvalid && !bready);
    wire next_aw_full = (aw_full || aw_take) && !do_write;
    wire next_w_full = (w_full || w_take) && !do_write;

    wire wr_pasg = do_write && (aw_addr == A_PASG) && !is_periph;
    wire wr_pull = do_write && (aw_addr == A_PULL) && !is_periph;
    wire wr_wdrv = do_write && (aw_addr == A_WDRV) && !is_periph;
    wire wr_status = do_write && (aw_addr == A_STATUS);
    wire wr_ok = wr_pasg || wr_pull || wr_wdrv || wr_status;

    // per-bit write permission from mode and first-write history
    wire [7:0] once_ok = is_special ? pasg_seen : ~pasg_seen;
    wire eclkd_ok = (op_mode == pebp_pkg::MODE_NORM_SINGLE) ? !pasg_seen[4] :
                    (op_mode == pebp_pkg::MODE_SPEC_SINGLE);
    wire ctest_ok = is_special && pasg_seen[6];
    wire [7:0] pasg_wmask = {once_ok[7], ctest_ok, once_ok[5], eclkd_ok, once_ok[3], once_ok[2],
                             1'b1, once_ok[0]};
    wire wdrv_ok = is_special ? wdrv_seen : !wdrv_seen;
    wire [7:0] pasg_written = (pasg & ~pasg_wmask) | (w_byte & pasg_wmask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pasg <= pasg_rst_val;
            pasg_seen <= 8'h00;
            pull_ctl <= pebp_pkg::PULL_RST;
            wdrv <= pebp_pkg::WDRV_RST;
            wdrv_seen <= 1'b0;
            narrow_hold <= (rst_mode == pebp_pkg::MODE_NORM_EXP_NARROW);
        end else begin
            if (wr_pasg && w_lane0) begin
                pasg <= pasg_written;
                pasg_seen <= 8'hFF;
                narrow_hold <= 1'b0;
            end
            if (wr_pull && w_lane0) begin
                pull_ctl <= w_byte & pebp_pkg::PORT_BITS_MASK;
            end
            if (wr_wdrv && w_lane0) begin
                if (wdrv_ok) begin
                    wdrv <= w_byte & pebp_pkg::PORT_BITS_MASK;
                end
                wdrv_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= pebp_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= awaddr;
            end
            if (w_take) begin
                w_byte <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
            if (do_write) begin
                bresp <= wr_ok ? pebp_pkg::RESP_OKAY : pebp_pkg::RESP_SLVERR;
            end
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            bvalid <= next_bvalid;
            awready <= !next_aw_full && !next_bvalid;
            wready <= !next_w_full && !next_bvalid;
        end
    end

    // read path: answer one cycle after the address is taken
    wire ar_take = arvalid && arready;
    wire next_rvalid = ar_take || (rvalid && !rready);
    wire rd_pasg = (araddr == A_PASG) && !is_periph;
    wire rd_pull = (araddr == A_PULL) && !is_periph;
    wire rd_wdrv = (araddr == A_WDRV) && !is_periph;
    wire rd_status = (araddr == A_STATUS);
    wire [31:0] status_word = (32'(op_mode) << pebp_pkg::STAT_MODE_LSB) |
                              (32'(pe_oe) << pebp_pkg::STAT_OE_LSB) |
                              (32'(pe_s2) << pebp_pkg::STAT_PIN_LSB);
    wire [31:0] rd_word = rd_pasg ? 32'(pasg) :
                          rd_pull ? 32'(pull_ctl) :
                          rd_wdrv ? 32'(wdrv) :
                          rd_status ? status_word : 32'h0000_0000;
    wire rd_ok = rd_pasg || rd_pull || rd_wdrv || rd_status;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= pebp_pkg::RESP_OKAY;
        end else begin
            if (ar_take) begin
                rdata <= rd_word;
                rresp <= rd_ok ? pebp_pkg::RESP_OKAY : pebp_pkg::RESP_SLVERR;
            end
            rvalid <= next_rvalid;
            arready <= !next_rvalid;
        end
    end

    // pin function selection
    wire sel7_bus = is_exp && !pasg.no_data_enable;
    wire sel7_cal = pasg.calib_ref_en && (is_single || is_periph || pasg.no_data_enable);
    wire pe7_bus_val = pasg.strobe_select ? !busctl.eclk : busctl.data_bus_en_out;
    wire sel6_pipe = pasg.pipe_status_out_en && is_exp;
    wire sel6_test = pasg.clkgen_test_en && (is_periph || is_spec_exp);
    wire sel4_e = !pasg.eclk_pin_disable && !(is_single && e_stretch);
    wire sel3_tag = is_spec_exp && pasg.low_strobe_en && debug_tag_active;
    wire sel3_strb = pasg.low_strobe_en && !is_single && !is_norm_narrow;
    wire sel2_rw = pasg.rw_pin_en && !is_single;

    wire [7:0] next_pe_out;
    wire [7:0] next_pe_oe;

    // strobe select only reaches PE7 through sel7_bus, which needs an expanded mode
    assign next_pe_out[7] = sel7_bus ? pe7_bus_val : sel7_cal ? busctl.calib_ref : gpio_data[7];
    assign next_pe_oe[7] = (sel7_bus || sel7_cal) || gpio_dir[7];
    assign next_pe_out[6] = sel6_pipe ? busctl.pipe[1] : sel6_test ? busctl.clkgen_test : gpio_data[6];
    assign next_pe_oe[6] = sel6_pipe || sel6_test || gpio_dir[6];
    assign next_pe_out[5] = sel6_pipe ? busctl.pipe[0] : gpio_data[5];
    assign next_pe_oe[5] = sel6_pipe || gpio_dir[5];
    assign next_pe_out[4] = sel4_e ? busctl.eclk : gpio_data[4];
    assign next_pe_oe[4] = !is_periph && (sel4_e || gpio_dir[4]);
    assign next_pe_out[3] = narrow_hold ? 1'b1 : sel3_tag ? 1'b0 :
                            sel3_strb ? busctl.low_byte_strobe : gpio_data[3];
    assign next_pe_oe[3] = narrow_hold || (!sel3_tag && (sel3_strb || gpio_dir[3]));
    assign next_pe_out[2] = sel2_rw ? busctl.rw : gpio_data[2];
    assign next_pe_oe[2] = sel2_rw || gpio_dir[2];
    // PE1 and PE0 are interrupt inputs and never drive
    assign next_pe_out[1:0] = 2'b00;
    assign next_pe_oe[1:0] = 2'b00;

    // pads; address/data ports lose their pulls outside single chip
    wire ab_free = is_single;
    wire [7:0] next_pull_a = {8{pull_ctl[pebp_pkg::PORT_A_BIT] && ab_free}} & ~dir_a;
    wire [7:0] next_pull_b = {8{pull_ctl[pebp_pkg::PORT_B_BIT] && ab_free}} & ~dir_b;
    wire [7:0] next_pull_e = {8{pull_ctl[pebp_pkg::PORT_E_BIT]}} & ~next_pe_oe & pebp_pkg::PE_PULL_PINS;
    wire [7:0] next_pull_g = {8{pull_ctl[pebp_pkg::PORT_G_BIT]}} & ~dir_g;
    wire [7:0] next_pull_h = {8{pull_ctl[pebp_pkg::PORT_H_BIT]}} & ~dir_h;

    // E clock for tagging: pin in peripheral mode, core clock otherwise
    wire eclk_now = is_periph ? pe_s2[pebp_pkg::PIN_ECLK] : busctl.eclk;
    logic eclk_q;
    wire eclk_fall = eclk_q && !eclk_now;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pe_out <= 8'h08;
            pe_oe <= (rst_mode == pebp_pkg::MODE_NORM_EXP_NARROW) ? 8'h08 : 8'h00;
            pull_a <= 8'h00;
            pull_b <= 8'h00;
            pull_e <= 8'h00;
            pull_g <= 8'h00;
            pull_h <= 8'h00;
            weak_drive <= 5'h00;
            eclk_q <= 1'b0;
            tag_low_byte <= 1'b0;
        end else begin
            pe_out <= next_pe_out;
            pe_oe <= next_pe_oe;
            pull_a <= next_pull_a;
            pull_b <= next_pull_b;
            pull_e <= next_pull_e;
            pull_g <= next_pull_g;
            pull_h <= next_pull_h;
            weak_drive <= wdrv[4:0];
            eclk_q <= eclk_now;
            tag_low_byte <= sel3_tag && eclk_fall && !pe_s2[pebp_pkg::PIN_STRB];
        end
    end

endmodule : pebp_top

// [inc/pebp_pkg.sv]
// shared types and constants for the port E bus pin assignment block
// assumes an AXI4-Lite master with 32-bit data and a single system clock
package pebp_pkg;

    // operating mode as seen on the mode strap pins; 3'h7 is not a legal mode
    typedef enum logic [2:0] {
        MODE_NORM_SINGLE = 3'h0,
        MODE_NORM_EXP_NARROW = 3'h1,
        MODE_NORM_EXP_WIDE = 3'h2,
        MODE_PERIPHERAL = 3'h3,
        MODE_SPEC_SINGLE = 3'h4,
        MODE_SPEC_EXP_NARROW = 3'h5,
        MODE_SPEC_EXP_WIDE = 3'h6
    } pebp_mode_t;

    // port_e_assignment layout, bit 7 down to bit 0
    typedef struct packed {
        logic no_data_enable;
        logic clkgen_test_en;
        logic pipe_status_out_en;
        logic eclk_pin_disable;
        logic low_strobe_en;
        logic rw_pin_en;
        logic calib_ref_en;
        logic strobe_select;
    } pebp_pasg_t;

    // bus control signals offered by the core for the port E pins
    typedef struct packed {
        logic eclk;
        logic data_bus_en_out;
        logic low_byte_strobe;
        logic rw;
        logic [1:0] pipe;
        logic clkgen_test;
        logic calib_ref;
    } pebp_busctl_t;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_PASG = 6'h0A;
    localparam logic [5:0] IDX_PULL = 6'h0C;
    localparam logic [5:0] IDX_WDRV = 6'h0D;
    localparam logic [5:0] IDX_STATUS = 6'h0E;

    // values after reset, per mode where it matters
    localparam logic [7:0] PASG_RST_NORM_EXP = 8'h00;
    localparam logic [7:0] PASG_RST_SPECIAL = 8'h2C;
    localparam logic [7:0] PASG_RST_PERIPH = 8'hD0;
    localparam logic [7:0] PASG_RST_NORM_SINGLE = 8'h90;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] WDRV_RST = 8'h00;

    // field positions in pull_control and reduced_drive_control
    localparam int PORT_A_BIT = 0;
    localparam int PORT_B_BIT = 1;
    localparam int PORT_E_BIT = 2;
    localparam int PORT_G_BIT = 3;
    localparam int PORT_H_BIT = 4;
    localparam logic [7:0] PORT_BITS_MASK = 8'h1F;

    // port E pins that own a pull device
    localparam logic [7:0] PE_PULL_PINS = 8'h8F;

    // port E pin positions of the bus control functions
    localparam int PIN_DENB = 7;
    localparam int PIN_PIPE1 = 6;
    localparam int PIN_PIPE0 = 5;
    localparam int PIN_ECLK = 4;
    localparam int PIN_STRB = 3;
    localparam int PIN_RW = 2;

    // status register field positions
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_OE_LSB = 8;
    localparam int STAT_PIN_LSB = 16;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pebp_pkg

// [testbench/pebp_asserts.sv]
// concurrent checks on the port E pin assignment block, watching its top ports only
// assumes the mode straps stay steady while reset is low
`timescale 1ns/1ns

module pebp_asserts (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // mode, directions and pads
    input wire logic [2:0] mode_pins,
    input wire logic [7:0] dir_g,
    input wire logic [7:0] pe_out,
    input wire logic [7:0] pe_oe,
    input wire logic [7:0] pull_a,
    input wire logic [7:0] pull_b,
    input wire logic [7:0] pull_e,
    input wire logic [7:0] pull_g,
    input wire logic tag_low_byte
);
    logic [2:0] md;
    logic sgl;

    // the mode is whatever the straps showed while reset was low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            md <= mode_pins;
        end
    end
    assign sgl = (md == 3'h0) || (md == 3'h4);

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pull_e_pins_a: assert property ((pull_e & 8'h70) == 8'h00)
        else $error("pull on a port E pin without pull device");
    pull_g_input_a: assert property ((pull_g & $past(dir_g)) == 8'h00)
        else $error("port G pull on an output pin");
    pull_ab_bus_a: assert property (!sgl |-> (pull_a | pull_b) == 8'h00)
        else $error("address bus port has a pull enabled");
    eclk_input_a: assert property (md == 3'h3 |-> !pe_oe[4])
        else $error("clock pin driven in peripheral mode");
    tag_pulse_a: assert property (tag_low_byte |=> !tag_low_byte)
        else $error("tag longer than one cycle");
    tag_mode_a: assert property (tag_low_byte |-> md == 3'h5 || md == 3'h6)
        else $error("tag outside special expanded modes");
    narrow_hold_a: assert property ($rose(aresetn) && md == 3'h1 |-> pe_oe[3] && pe_out[3])
        else $error("strobe pin not driven high after reset");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");

    cover property (tag_low_byte);
    cover property (pull_g != 8'h00);
    cover property ($rose(aresetn) && md == 3'h1);
endmodule : pebp_asserts

// [testbench/pebp_bus_partner.sv]
// expansion bus side of port E: answers the pads the block releases
// assumes released pads float unless the port E pull is on
`timescale 1ns/1ns

module pebp_bus_partner (
    // system
    input wire logic aclk,
    // pads from the block
    input wire logic [7:0] pe_out,
    input wire logic [7:0] pe_oe,
    input wire logic [7:0] pull_e,
    // bench command: pull the strobe pad low
    input wire logic hold_lo,
    // pad levels seen by the block
    output logic [7:0] pe_in
);
    logic tgl = 1'h0;
    logic ext_e = 1'h0;

    // free-running e clock from the far side, seen whenever the pad is released
    always #200 ext_e = ~ext_e;

    // a floating pad must not keep showing its last driven level
    always @(posedge aclk) begin
        tgl <= ~tgl;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pe_oe[i]) begin
                pe_in[i] = pe_out[i];
            end else if (i == 3 && hold_lo) begin
                pe_in[i] = 1'h0;
            end else if (i == 4) begin
                pe_in[i] = ext_e;
            end else begin
                pe_in[i] = pull_e[i] | tgl ^ i[0];
            end
        end
    end
endmodule : pebp_bus_partner

// [testbench/tb_top.sv]
// self-checking bench for the port E pin assignment block, one pass per mode
// assumes the bus partner model on port E and a reset per mode change
`timescale 1ns/1ns

module tb_top;
    localparam logic [7:0] A_PE = {pebp_pkg::IDX_PASG, 2'h0};
    localparam logic [7:0] A_PU = {pebp_pkg::IDX_PULL, 2'h0};
    localparam logic [7:0] A_RD = {pebp_pkg::IDX_WDRV, 2'h0};
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic e_stretch = 1'h0, debug_tag_active = 1'h0, hold_lo = 1'h0, sgl;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, gpio_data = 8'h00, gpio_dir = 8'h00;
    logic [7:0] dir_a = 8'h00, dir_b = 8'h00, dir_g = 8'h00, dir_h = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [3:0] wstrb = 4'h0;
    logic [2:0] mode_pins = 3'h0;
    pebp_pkg::pebp_busctl_t busctl = '0;
    logic awready, wready, bvalid, arready, rvalid, tag_low_byte;
    logic [1:0] bresp, rresp, rr, ex;
    logic [7:0] pe_in, pe_out, pe_oe, pull_a, pull_b, pull_e, pull_g, pull_h, pasg, pull, rdv;
    logic [4:0] weak_drive;
    logic [15:0] pe;
    int n_errors = 0, tests_run = 0, cyc = 0, m, n;
    bit pw, rw;

    pebp_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .mode_pins, .e_stretch, .debug_tag_active, .busctl, .gpio_data, .gpio_dir, .pe_in, .pe_out,
        .pe_oe, .dir_a, .dir_b, .dir_g, .dir_h, .pull_a, .pull_b, .pull_e, .pull_g, .pull_h,
        .weak_drive, .tag_low_byte);
    pebp_bus_partner u_part (.aclk, .pe_out, .pe_oe, .pull_e, .hold_lo, .pe_in);

    always #25 aclk = ~aclk;

    task automatic final_report();
        $display("mismatches %0d of %0d compares", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        chk(32'(bresp), 32'(er));
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rv = rdata;
        rr = rresp;
        rready <= 1'h0;
    endtask : rd

    // absent registers answer with an error and zero data
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(32'(rr), 32'(ex));
        chk(rv, m == 3 ? 32'h0000_0000 : 32'(e));
    endtask : rchk

    function automatic logic [7:0] pasg_upd(input logic [7:0] d);
        logic [7:0] k;
        k = 8'h02;
        if (m == 4 || (m == 0 && !pw)) k[4] = 1'h1;
        if (m > 3 && pw) k[6] = 1'h1;
        if ((m > 3) == pw) k = k | 8'hAD;
        return (pasg & ~k) | (d & k);
    endfunction : pasg_upd

    function automatic logic [15:0] pin_exp();
        logic [7:0] o, e;
        logic xp;
        xp = !sgl && m != 3;
        o = gpio_data;
        e = gpio_dir & 8'hFC;
        if (xp && !pasg[7]) begin
            o[7] = pasg[0] ? ~busctl.eclk : busctl.data_bus_en_out;
            e[7] = 1'h1;
        end else if (pasg[1] && (sgl || m == 3 || pasg[7])) begin
            o[7] = busctl.calib_ref;
            e[7] = 1'h1;
        end
        if (xp && pasg[5]) begin
            o[6:5] = busctl.pipe;
            e[6:5] = 2'h3;
        end else if (pasg[6] && (m == 3 || m > 4)) begin
            o[6] = busctl.clkgen_test;
            e[6] = 1'h1;
        end
        if (m == 3) begin
            e[4] = 1'h0;
        end else if (!pasg[4] && !(sgl && e_stretch)) begin
            o[4] = busctl.eclk;
            e[4] = 1'h1;
        end
        if (m == 1 && !pw) begin
            o[3] = 1'h1;
            e[3] = 1'h1;
        end else if (pasg[3] && xp && m != 1) begin
            o[3] = busctl.low_byte_strobe;
            e[3] = 1'h1;
        end
        if (pasg[2] && !sgl) begin
            o[2] = busctl.rw;
            e[2] = 1'h1;
        end
        return {e, o & e};
    endfunction : pin_exp

    task automatic pins();
        repeat (4) begin
            @(posedge aclk);
            rv = $urandom;
            busctl <= rv[7:0];
            gpio_data <= rv[15:8];
            gpio_dir <= rv[23:16];
            dir_g <= rv[31:24];
            rv = $urandom;
            dir_a <= rv[7:0];
            dir_b <= rv[15:8];
            dir_h <= rv[23:16];
            e_stretch <= rv[24];
            repeat (3) @(posedge aclk);
            pe = pin_exp();
            chk(32'(pe_oe), 32'(pe[15:8]));
            chk(32'(pe_out & pe[15:8]), 32'(pe[7:0]));
            chk(32'(pull_e), 32'(pull[2] ? ~pe[15:8] & 8'h8F : 8'h00));
            chk({pull_a, pull_b, pull_g, pull_h}, {sgl && pull[0] ? ~dir_a : 8'h00,
                sgl && pull[1] ? ~dir_b : 8'h00, pull[3] ? ~dir_g : 8'h00, pull[4] ? ~dir_h : 8'h00});
            chk(32'(weak_drive), 32'(rdv[4:0]));
        end
    endtask : pins

    // the partner holds the strobe pad low across a falling E clock
    task automatic tag_scn();
        @(posedge aclk);
        debug_tag_active <= 1'h1;
        hold_lo <= 1'h1;
        busctl <= 8'h80;
        repeat (4) @(posedge aclk);
        busctl <= 8'h00;
        n = 0;
        repeat (8) begin
            @(posedge aclk);
            if (tag_low_byte === 1'h1) n++;
        end
        chk(32'(n), 32'h0000_0001);
        debug_tag_active <= 1'h0;
        hold_lo <= 1'h0;
    endtask : tag_scn

    task automatic rst();
        mode_pins <= 3'(m);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        pasg = m == 0 ? pebp_pkg::PASG_RST_NORM_SINGLE : m == 3 ? pebp_pkg::PASG_RST_PERIPH :
            m < 3 ? pebp_pkg::PASG_RST_NORM_EXP : pebp_pkg::PASG_RST_SPECIAL;
        pull = 8'h00;
        rdv = 8'h00;
        pw = 1'b0;
        rw = 1'b0;
        sgl = m == 0 || m == 4;
        ex = m == 3 ? 2'h2 : 2'h0;
    endtask : rst

    initial begin
        rv = $urandom(32'hf62b_8ec6);
        for (m = 0; m < 7; m++) begin
            rst();
            if (m == 5) tag_scn();
            pins();
            rchk(A_PE, pasg);
            rchk(A_PU, 8'h00);
            rchk(A_RD, 8'h00);
            wr(8'h3C, 32'h0000_00FF, 2'h2);
            rd(8'h3C);
            chk(32'(rr), 32'h0000_0002);
            chk(rv, 32'h0000_0000);
            repeat (3) begin
                rv = $urandom;
                wr(A_PE, rv, ex);
                if (m != 3) pasg = pasg_upd(rv[7:0]);
                pw = pw | (m != 3);
                rv = $urandom;
                wr(A_RD, rv, ex);
                if (m != 3 && (m > 3) == rw) rdv = rv[7:0] & 8'h1F;
                rw = rw | (m != 3);
                rv = $urandom;
                wr(A_PU, rv, ex);
                if (m != 3) pull = rv[7:0] & 8'h1F;
                rchk(A_PE, pasg);
                rchk(A_RD, rdv);
                rchk(A_PU, pull);
            end
            pins();
            // status shows the latched mode and the pad enables just checked
            rd({pebp_pkg::IDX_STATUS, 2'h0});
            chk(32'({rr, rv[15:0]}), 32'({2'h0, pe[15:8], 8'(m)}));
        end
        final_report();
    end
endmodule : tb_top

bind pebp_top pebp_asserts u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .arvalid, .arready, .rvalid, .mode_pins, .dir_g, .pe_out, .pe_oe, .pull_a, .pull_b, .pull_e,
    .pull_g, .tag_low_byte);
